// *** ceac_core.sv ***
// Condition evaluation, alignment check and PC-relative base unit with APB registers
`timescale 1ns/1ps
`default_nettype none
module ceac_core
    import ceac_pkg::*;
(
    input wire logic pclk, // Core clock
    input wire logic presetn, // Async reset, low active
    input wire logic psel, // APB select
    input wire logic penable, // APB access phase
    input wire logic pwrite, // APB write
    input wire logic [AW-1:0] paddr, // APB byte address
    input wire logic [XLEN-1:0] pwdata, // APB write data
    output var logic [XLEN-1:0] prdata, // APB read data
    output var logic pready, // APB ready
    output var logic pslverr, // APB error on unmapped address
    input wire ceac_req_t req, // Instruction to check
    output var ceac_resp_t resp, // Verdict, one cycle later
    output var ceac_flags_t flags, // Program status flags
    output var logic irq // Level interrupt
);
    typedef struct packed {
        logic trap;
        ceac_flags_t flags;
        ceac_evt_t status;
        ceac_evt_t mask;
        logic [XLEN-1:0] fault_addr;
        logic [3:0] it_cond;
        logic [3:0] it_else;
        logic [2:0] it_left;
        logic [XLEN-1:0] prdata;
        logic pready;
        logic pslverr;
        logic irq;
        ceac_resp_t resp;
    } ceac_state_t;
    localparam ceac_state_t ST_RST = '0;

    ceac_state_t st;
    ceac_state_t nx;
    logic wr;
    logic in_it;
    logic [3:0] eff_cond;
    logic pass;
    logic it_misuse;
    logic unal;
    logic forbid;
    logic pcsel_bad;
    logic set_f;
    logic [XLEN:0] sum;
    logic [XLEN-1:0] base;
    ceac_size_t sz;
    ceac_evt_t evt;
    ceac_flags_t alu_f;
    ceac_resp_t r;

    function automatic logic cond_pass(input logic [3:0] c, input ceac_flags_t f);
        logic t;
        t = 1'b1;
        unique case (c[3:1])
            3'h0: t = f.z;
            3'h1: t = f.c;
            3'h2: t = f.n;
            3'h3: t = f.v;
            3'h4: t = f.c & ~f.z;
            3'h5: t = (f.n == f.v);
            3'h6: t = ~f.z & (f.n == f.v);
            3'h7: t = 1'b1;
        endcase
        return (c[0] && c[3:1] != COND_GRP_AL) ? ~t : t;
    endfunction : cond_pass

    function automatic ceac_size_t size_of(input ceac_op_t op);
        unique case (op)
            OP_BYTE_LOAD, OP_BYTE_STORE: return SZ_BYTE;
            OP_HALF_LOAD, OP_HALF_LOAD_USER, OP_SIGNED_HALF_LOAD, OP_SIGNED_HALF_LOAD_USER,
            OP_HALF_STORE, OP_HALF_STORE_USER: return SZ_HALF;
            OP_WORD_LOAD, OP_WORD_LOAD_USER, OP_WORD_STORE, OP_WORD_STORE_USER,
            OP_DUAL_WORD_LOAD, OP_DUAL_WORD_STORE, OP_MULTI_REG_LOAD, OP_MULTI_REG_STORE,
            OP_PUSH, OP_POP, OP_EXCLUSIVE_LOAD, OP_EXCLUSIVE_STORE: return SZ_WORD;
            default: return SZ_NONE;
        endcase
    endfunction : size_of

    function automatic logic unal_ok(input ceac_op_t op);
        unique case (op)
            OP_WORD_LOAD, OP_WORD_LOAD_USER, OP_HALF_LOAD, OP_HALF_LOAD_USER,
            OP_SIGNED_HALF_LOAD, OP_SIGNED_HALF_LOAD_USER, OP_WORD_STORE,
            OP_WORD_STORE_USER, OP_HALF_STORE, OP_HALF_STORE_USER: return 1'b1;
            default: return 1'b0;
        endcase
    endfunction : unal_ok

    // Classes that write a destination register
    function automatic logic writes_reg(input ceac_op_t op);
        unique case (op)
            OP_WORD_LOAD, OP_WORD_LOAD_USER, OP_HALF_LOAD, OP_HALF_LOAD_USER,
            OP_SIGNED_HALF_LOAD, OP_SIGNED_HALF_LOAD_USER, OP_BYTE_LOAD,
            OP_DUAL_WORD_LOAD, OP_MULTI_REG_LOAD, OP_POP, OP_EXCLUSIVE_LOAD,
            OP_EXCLUSIVE_STORE, OP_PC_REL_ADDR, OP_ADD, OP_SUB, OP_MOVE,
            OP_CALL_DIRECT: return 1'b1;
            default: return 1'b0;
        endcase
    endfunction : writes_reg

    // Next state: APB slave, checker verdict, flags, IT tracking, events
    always_comb begin
        nx = st;
        r = '0;
        evt = '0;
        alu_f = st.flags;
        sum = '0;
        set_f = 1'b0;
        // Zero wait state: ready comes in the access phase after every setup
        nx.pready = psel & ~penable;
        nx.pslverr = 1'b0;
        nx.prdata = '0;
        if (psel && !penable) begin
            unique case (paddr)
                OFF_CFG: nx.prdata[CFG_TRAP_BIT] = st.trap;
                OFF_FLAGS: nx.prdata[FLAGS_W-1:0] = st.flags;
                OFF_STAT: nx.prdata[EVT_W-1:0] = st.status;
                OFF_MASK: nx.prdata[EVT_W-1:0] = st.mask;
                OFF_FADDR: nx.prdata = st.fault_addr;
                default: nx.pslverr = 1'b1;
            endcase
        end
        wr = psel & penable & st.pready & pwrite & ~st.pslverr;
        if (wr && paddr == OFF_CFG) begin
            nx.trap = pwdata[CFG_TRAP_BIT];
        end
        if (wr && paddr == OFF_MASK) begin
            nx.mask = pwdata[EVT_W-1:0];
        end
        // Software flag write; a flag-setting instruction in the same cycle overrides it
        if (wr && paddr == OFF_FLAGS) begin
            nx.flags = pwdata[FLAGS_W-1:0];
        end
        in_it = (st.it_left != '0);
        eff_cond = st.it_else[0] ? (st.it_cond ^ COND_INV) : st.it_cond;
        eff_cond = in_it ? eff_cond : req.cond;
        it_misuse = req.valid && ((!in_it && req.cond != COND_AL
                    && req.op != OP_JUMP_DIRECT && req.op != OP_IF_THEN_PREFIX)
                    || (in_it && req.op == OP_IF_THEN_PREFIX));
        // the prefix itself is not gated
        pass = (req.op == OP_IF_THEN_PREFIX) ? 1'b1 : cond_pass(eff_cond, st.flags);
        sz = size_of(req.op);
        unique case (sz)
            SZ_HALF: unal = req.addr[0];
            SZ_WORD: unal = |req.addr[1:0];
            default: unal = 1'b0;
        endcase
        forbid = unal & (st.trap | ~unal_ok(req.op));
        pcsel_bad = (req.op == OP_JUMP_INDIRECT) & ~req.opb[PC_SEL_BIT];
        evt.usage = it_misuse;
        evt.unalign = req.valid & pass & ~it_misuse & forbid;
        evt.pcsel = req.valid & pass & ~it_misuse & pcsel_bad;
        base = req.pc + PC_STEP_WIDE;
        unique case (req.op)
            OP_JUMP_DIRECT, OP_CALL_DIRECT, OP_ZERO_TEST_JUMP, OP_NONZERO_TEST_JUMP: ;
            default: base = base & WORD_BASE_MASK;
        endcase
        r.valid = req.valid;
        r.kind = evt;
        r.fault = |evt;
        r.exec = req.valid & pass & ~r.fault;
        r.base = base;
        r.next_pc = req.pc + (req.wide ? PC_STEP_WIDE : PC_STEP_NARROW);
        r.mem_en = r.exec & (sz != SZ_NONE);
        r.wr_en = r.exec & writes_reg(req.op);
        unique case (req.op)
            OP_ADD, OP_COMPARE_ADD: begin
                sum = {1'b0, req.opa} + {1'b0, req.opb};
                alu_f.c = sum[XLEN];
                alu_f.v = (req.opa[SIGN_BIT] == req.opb[SIGN_BIT])
                          & (sum[SIGN_BIT] != req.opa[SIGN_BIT]);
            end
            OP_SUB, OP_COMPARE_SUB: begin
                sum = {1'b0, req.opa} + {1'b0, ~req.opb} + {{XLEN{1'b0}}, 1'b1};
                alu_f.c = sum[XLEN];
                alu_f.v = (req.opa[SIGN_BIT] != req.opb[SIGN_BIT])
                          & (sum[SIGN_BIT] != req.opa[SIGN_BIT]);
            end
            OP_MOVE: begin
                // Operand arrives already shifted; its carry-out comes alongside
                sum = {1'b0, req.opb};
                alu_f.c = req.shc;
            end
            default: sum = '0;
        endcase
        alu_f.n = sum[SIGN_BIT];
        alu_f.z = (sum[XLEN-1:0] == '0);
        unique case (req.op)
            OP_COMPARE_ADD, OP_COMPARE_SUB: set_f = 1'b1;
            OP_ADD, OP_SUB, OP_MOVE: set_f = req.set_flags;
            default: set_f = 1'b0;
        endcase
        if (r.exec && set_f) begin
            nx.flags = alu_f;
        end
        // Branch decisions and result value
        r.result = sum[XLEN-1:0];
        r.target = base + req.opb;
        unique case (req.op)
            OP_JUMP_DIRECT: r.taken = r.exec;
            OP_CALL_DIRECT: begin
                r.taken = r.exec;
                r.result = r.next_pc | PC_STEP_NARROW >> PC_ALIGN_BIT;
            end
            OP_ZERO_TEST_JUMP: r.taken = r.exec & (req.opa == '0);
            OP_NONZERO_TEST_JUMP: r.taken = r.exec & (req.opa != '0);
            OP_JUMP_INDIRECT: begin
                r.taken = r.exec;
                r.target = req.opb & ~(PC_STEP_NARROW >> PC_ALIGN_BIT);
            end
            OP_PC_REL_ADDR: r.result = base + req.opb;
            default: r.taken = 1'b0;
        endcase
        nx.resp = r;
        if (req.valid && in_it) begin
            nx.it_left = st.it_left - 3'h1;
            nx.it_else = st.it_else >> 1;
        end
        if (r.exec && req.op == OP_IF_THEN_PREFIX) begin
            nx.it_cond = req.cond;
            nx.it_else = req.it_else;
            nx.it_left = req.it_len;
        end
        // Fault address: the data address, or the bad jump target
        if (evt.unalign) begin
            nx.fault_addr = req.addr;
        end else if (evt.pcsel) begin
            nx.fault_addr = req.opb;
        end
        // Write one to clear; a new event in the same cycle wins
        nx.status = st.status;
        if (wr && paddr == OFF_STAT) begin
            nx.status = st.status & ~pwdata[EVT_W-1:0];
        end
        nx.status = nx.status | evt;
        nx.irq = |(nx.status & nx.mask);
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= ST_RST;
        end else begin
            st <= nx;
        end
    end

    assign prdata = st.prdata;
    assign pready = st.pready;
    assign pslverr = st.pslverr;
    assign resp = st.resp;
    assign flags = st.flags;
    assign irq = st.irq;

    // Checks on the verdict path and on APB ready timing
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_plain(ceac_op_t o);
        req.valid && req.op == o && !in_it && req.cond == COND_AL;
    endsequence
    // The prefix carries the block condition, so it is not a plain always-true request
    sequence s_it_open;
        req.valid && req.op == OP_IF_THEN_PREFIX && !in_it && req.it_len != '0;
    endsequence

    AST_BYTE_ALIGNED: assert property (s_plain(OP_BYTE_LOAD) |=> !resp.kind.unalign)
        else $error("byte access flagged unaligned");
    AST_HALF_UNAL_OK: assert property (s_plain(OP_HALF_LOAD_USER) ##0 (req.addr[0] && !st.trap)
        |=> resp.exec && resp.mem_en)
        else $error("permitted unaligned halfword load refused");
    AST_DUAL_FAULT: assert property (s_plain(OP_DUAL_WORD_LOAD) ##0 req.addr[1]
        |=> resp.fault && !resp.mem_en && !resp.wr_en)
        else $error("unaligned dual load not faulted");
    AST_TRAP_ALL: assert property (s_plain(OP_WORD_STORE_USER) ##0 (req.addr[0] && st.trap)
        |=> resp.kind.unalign && st.status.unalign)
        else $error("trap enable missed unaligned store");
    AST_BASE_DIRECT: assert property (s_plain(OP_CALL_DIRECT)
        |=> resp.base == $past(req.pc) + PC_STEP_WIDE)
        else $error("direct call base wrong");
    AST_BASE_WORD: assert property (s_plain(OP_PC_REL_ADDR)
        |=> resp.base == (($past(req.pc) + PC_STEP_WIDE) & WORD_BASE_MASK))
        else $error("relative base not word aligned");
    AST_FAIL_QUIET: assert property (req.valid && in_it && !pass && !wr
        |=> !resp.exec && !resp.wr_en && !resp.fault && $stable(st.flags))
        else $error("failed condition left effects");
    AST_FLAG_HOLD: assert property (s_plain(OP_ADD) ##0 (!req.set_flags && !wr)
        |=> $stable(st.flags))
        else $error("flags changed without request");
    AST_IT_LOAD: assert property (s_it_open |=> st.it_left == $past(req.it_len))
        else $error("if-then block not opened");
    AST_ZERO_NEG: assert property (s_plain(OP_SUB) ##0 req.set_flags
        |=> st.flags.z == (resp.result == '0) && st.flags.n == resp.result[SIGN_BIT])
        else $error("negative or zero flag wrong");
    AST_CMP_NOWRITE: assert property (s_plain(OP_COMPARE_SUB)
        |=> !resp.wr_en && st.flags.z == ($past(req.opa) == $past(req.opb)))
        else $error("compare wrote a register or wrong zero");
    AST_BIT0_FAULT: assert property (s_plain(OP_JUMP_INDIRECT) ##0 !req.opb[PC_SEL_BIT]
        |=> resp.kind.pcsel && !resp.taken)
        else $error("indirect jump with bit 0 clear taken");
    AST_APB_READY: assert property (psel && !penable |=> pready ##1 !pready)
        else $error("ready not one cycle after setup");
endmodule : ceac_core
`default_nettype wire

// *** ceac_core_test.sv ***
// Self-checking bench for the condition, alignment and PC-base unit
`timescale 1ns/1ps
`default_nettype none
module ceac_core_test;
    import ceac_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [AW-1:0] paddr = '0;
    logic [XLEN-1:0] pwdata = '0;
    logic [XLEN-1:0] prdata;
    logic pready;
    logic pslverr;
    logic issue = 1'b0;
    ceac_req_t ins = '0;
    ceac_req_t req;
    ceac_resp_t resp;
    ceac_flags_t flags;
    logic irq;
    logic [XLEN-1:0] rd_q;
    logic rd_err;
    int n_mismatch = 0;
    int samples_checked = 0;
    int cyc = 0;
    ceac_op_t al_op [10] = '{OP_WORD_LOAD, OP_HALF_LOAD_USER, OP_SIGNED_HALF_LOAD,
        OP_WORD_STORE_USER, OP_HALF_STORE, OP_BYTE_LOAD, OP_DUAL_WORD_LOAD,
        OP_MULTI_REG_STORE, OP_EXCLUSIVE_LOAD, OP_PUSH};
    ceac_op_t pc_op [6] = '{OP_JUMP_DIRECT, OP_CALL_DIRECT, OP_ZERO_TEST_JUMP,
        OP_NONZERO_TEST_JUMP, OP_PC_REL_ADDR, OP_WORD_LOAD};

    always #12.5 pclk = ~pclk;

    ceac_core ceac_core_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .req(req), .resp(resp), .flags(flags), .irq(irq));
    ceac_stream ceac_stream_i (.pclk(pclk), .presetn(presetn), .issue(issue), .ins(ins),
        .req(req));

    task stop_test();
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : stop_test

    task chk(input logic [31:0] g, input logic [31:0] e);
        samples_checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("[ERR] %0t got %h expected %h", $time, g, e);
        end
    endtask : chk

    // One APB transfer; held until pready is seen at a rising edge
    task apb(input logic w, input logic [AW-1:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd_q = prdata;
        rd_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // Let the write settle so callers see registered effects
        #1;
    endtask : apb

    function automatic ceac_req_t mk(input ceac_op_t op, input logic [3:0] c,
        input logic [31:0] pc, a, x, y, input logic sf);
        ceac_req_t r;
        r = '0;
        r.valid = 1'b1;
        r.op = op;
        r.cond = c;
        r.pc = pc;
        r.addr = a;
        r.opa = x;
        r.opb = y;
        r.set_flags = sf;
        r.wide = 1'b1;
        return r;
    endfunction : mk

    // Response is registered one cycle after the stream presents the request
    task send(input ceac_req_t r);
        @(posedge pclk);
        issue <= 1'b1;
        ins <= r;
        @(posedge pclk);
        issue <= 1'b0;
        @(posedge pclk);
        #1;
    endtask : send

    task fl(input ceac_op_t op, input logic [31:0] x, y, input logic sf, sh,
        input logic [3:0] fe, input logic we);
        ceac_req_t r;
        r = mk(op, COND_AL, 32'h0, 32'h0, x, y, sf);
        r.shc = sh;
        send(r);
        chk({28'h0, flags}, {28'h0, fe});
        chk({31'h0, resp.wr_en}, {31'h0, we});
    endtask : fl

    // Hang guard, far above the roughly 190 cycles the tests need
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_mismatch++;
            stop_test();
        end
    end

    initial begin
        ceac_req_t r;
        logic ef;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        // Register reset values, unmapped address refused
        apb(1'b0, OFF_CFG, 32'h0);
        chk(rd_q, 32'h0);
        apb(1'b0, OFF_FLAGS, 32'h0);
        chk(rd_q, 32'h0);
        apb(1'b0, OFF_MASK, 32'h0);
        chk(rd_q, 32'h0);
        apb(1'b0, 8'h20, 32'h0);
        chk({31'h0, rd_err}, 32'h1);
        $display("test registers done");
        // Three passes: trap off unaligned, trap on unaligned, trap on aligned
        for (int t = 0; t < 3; t++) begin
            if (t == 1) apb(1'b1, OFF_CFG, 32'h1);
            for (int i = 0; i < 10; i++) begin
                send(mk(al_op[i], COND_AL, 32'h0, (t == 2) ? 32'h1000 : 32'h1003, 0, 0, 0));
                ef = (t == 2) ? 1'b0 : (t == 1) ? (i != 5) : (i > 5);
                chk({31'h0, resp.fault}, {31'h0, ef});
                chk({31'h0, resp.mem_en}, {31'h0, !ef});
                chk({31'h0, resp.kind.unalign}, {31'h0, ef});
            end
            if (t == 0) chk({31'h0, irq}, 32'h0);
        end
        apb(1'b1, OFF_CFG, 32'h0);
        apb(1'b0, OFF_STAT, 32'h0);
        chk(rd_q, 32'h1);
        apb(1'b1, OFF_MASK, 32'h1);
        chk({31'h0, irq}, 32'h1);
        apb(1'b1, OFF_STAT, 32'h1);
        chk({31'h0, irq}, 32'h0);
        apb(1'b0, OFF_FADDR, 32'h0);
        chk(rd_q, 32'h1003);
        $display("test alignment done");
        // PC-relative base for direct and word-aligned label users
        for (int i = 0; i < 6; i++) begin
            send(mk(pc_op[i], COND_AL, 32'h102, 32'h1000, 0, 32'h10, 0));
            chk(resp.base, (i < 4) ? 32'h106 : 32'h104);
            if (i == 1) chk(resp.result, 32'h107);
        end
        r = mk(OP_PC_REL_ADDR, COND_AL, 32'h102, 0, 0, 0, 0);
        r.wide = 1'b0;
        send(r);
        chk(resp.base, 32'h104);
        chk(resp.next_pc, 32'h104);
        send(mk(OP_JUMP_INDIRECT, COND_AL, 32'h0, 0, 0, 32'h200, 0));
        chk({31'h0, resp.fault}, 32'h1);
        chk({31'h0, resp.taken}, 32'h0);
        send(mk(OP_JUMP_INDIRECT, COND_AL, 32'h0, 0, 0, 32'h201, 0));
        chk({31'h0, resp.fault}, 32'h0);
        chk(resp.target, 32'h200);
        $display("test pc base done");
        // Flag updates: compares, plain add, subtract, overflow, move carry
        apb(1'b1, OFF_FLAGS, 32'h0);
        fl(OP_COMPARE_SUB, 32'h5, 32'h5, 1'b0, 1'b0, 4'h6, 1'b0);
        fl(OP_COMPARE_ADD, 32'h8000_0000, 32'h8000_0000, 0, 0, 4'h7, 0);
        fl(OP_ADD, 32'h1, 32'h1, 1'b0, 1'b0, 4'h7, 1'b1);
        fl(OP_SUB, 32'h3, 32'h5, 1'b1, 1'b0, 4'h8, 1'b1);
        chk(resp.result, 32'hFFFF_FFFE);
        fl(OP_ADD, 32'h7FFF_FFFF, 32'h1, 1'b1, 1'b0, 4'h9, 1'b1);
        fl(OP_MOVE, 32'h0, 32'h0, 1'b1, 1'b1, 4'h7, 1'b1);
        $display("test flags done");
        // Conditions under a prefix block, and misuse outside one
        apb(1'b1, OFF_FLAGS, 32'h4);
        r = mk(OP_IF_THEN_PREFIX, 4'h0, 0, 0, 0, 0, 0);
        r.it_len = 3'd1;
        send(r);
        send(mk(OP_ADD, 4'h0, 0, 0, 32'h1, 32'h1, 1'b0));
        chk({31'h0, resp.exec}, 32'h1);
        r.cond = 4'h1;
        send(r);
        send(mk(OP_ADD, 4'h1, 0, 0, 32'h1, 32'h1, 1'b1));
        chk({31'h0, resp.exec}, 32'h0);
        chk({29'h0, resp.wr_en, resp.fault, resp.mem_en}, 32'h0);
        chk({28'h0, flags}, 32'h4);
        send(mk(OP_ADD, 4'h0, 0, 0, 32'h1, 32'h1, 1'b0));
        chk({31'h0, resp.fault}, 32'h1);
        chk({29'h0, resp.kind}, 32'h2);
        $display("test conditions done");
        stop_test();
    end
endmodule : ceac_core_test
`default_nettype wire

// *** ceac_pkg.sv ***
// Shared constants and types for the condition, alignment and PC-base checker
package ceac_pkg;
    localparam int unsigned XLEN = 32;
    localparam int unsigned AW = 8;
    // Register byte offsets
    localparam logic [AW-1:0] OFF_CFG = 8'h00;
    localparam logic [AW-1:0] OFF_FLAGS = 8'h04;
    localparam logic [AW-1:0] OFF_STAT = 8'h08;
    localparam logic [AW-1:0] OFF_MASK = 8'h0C;
    localparam logic [AW-1:0] OFF_FADDR = 8'h10;
    localparam int unsigned CFG_TRAP_BIT = 0;
    localparam int unsigned PC_ALIGN_BIT = 1;
    localparam int unsigned PC_SEL_BIT = 0;
    localparam int unsigned SIGN_BIT = XLEN - 1;
    localparam logic [XLEN-1:0] PC_STEP_WIDE = 32'h0000_0004;
    localparam logic [XLEN-1:0] PC_STEP_NARROW = 32'h0000_0002;
    localparam logic [XLEN-1:0] WORD_BASE_MASK = 32'hFFFF_FFFD;
    localparam logic [3:0] COND_AL = 4'hE;
    localparam logic [3:0] COND_INV = 4'h1;
    localparam logic [2:0] COND_GRP_AL = 3'h7;
    // Condition flags, low four bits of the flag register
    typedef struct packed {
        logic n;
        logic z;
        logic c;
        logic v;
    } ceac_flags_t;
    localparam int unsigned FLAGS_W = 4;
    // Sticky events, one status bit each
    typedef struct packed {
        logic pcsel;
        logic usage;
        logic unalign;
    } ceac_evt_t;
    localparam int unsigned EVT_W = 3;
    typedef enum logic [1:0] {SZ_NONE, SZ_BYTE, SZ_HALF, SZ_WORD} ceac_size_t;
    // Instruction classes seen by the checker
    typedef enum logic [5:0] {
        OP_NOP, OP_WORD_LOAD, OP_WORD_LOAD_USER, OP_HALF_LOAD, OP_HALF_LOAD_USER,
        OP_SIGNED_HALF_LOAD, OP_SIGNED_HALF_LOAD_USER, OP_WORD_STORE, OP_WORD_STORE_USER,
        OP_HALF_STORE, OP_HALF_STORE_USER, OP_BYTE_LOAD, OP_BYTE_STORE,
        OP_DUAL_WORD_LOAD, OP_DUAL_WORD_STORE, OP_MULTI_REG_LOAD, OP_MULTI_REG_STORE,
        OP_PUSH, OP_POP, OP_EXCLUSIVE_LOAD, OP_EXCLUSIVE_STORE, OP_EXCLUSIVE_CLEAR,
        OP_PC_REL_ADDR, OP_ADD, OP_SUB, OP_COMPARE_SUB, OP_COMPARE_ADD, OP_MOVE,
        OP_JUMP_DIRECT, OP_CALL_DIRECT, OP_ZERO_TEST_JUMP, OP_NONZERO_TEST_JUMP,
        OP_JUMP_INDIRECT, OP_IF_THEN_PREFIX
    } ceac_op_t;
    typedef struct packed {
        logic valid;
        ceac_op_t op;
        logic [3:0] cond;
        logic [3:0] it_else;
        logic [2:0] it_len;
        logic set_flags;
        logic wide;
        logic shc;
        logic [XLEN-1:0] pc;
        logic [XLEN-1:0] addr;
        logic [XLEN-1:0] opa;
        logic [XLEN-1:0] opb;
    } ceac_req_t;
    typedef struct packed {
        logic valid;
        logic exec;
        logic mem_en;
        logic wr_en;
        logic taken;
        logic fault;
        ceac_evt_t kind;
        logic [XLEN-1:0] result;
        logic [XLEN-1:0] base;
        logic [XLEN-1:0] target;
        logic [XLEN-1:0] next_pc;
    } ceac_resp_t;
endpackage : ceac_pkg

// *** ceac_stream.sv ***
// Instruction stream model feeding the checker one instruction per request
`timescale 1ns/1ps
`default_nettype none
module ceac_stream
    import ceac_pkg::*;
(
    input wire logic pclk, // Core clock
    input wire logic presetn, // Async reset, low active
    input wire logic issue, // Present ins on the next cycle
    input wire ceac_req_t ins, // Instruction from program order
    output var ceac_req_t req // Request to the checker
);
    ceac_req_t idle;

    // Idle word: every field flipped, valid held low
    always_comb begin
        idle = ~req;
        idle.valid = 1'b0;
    end

    // program supplies prefix
    // Idle fields toggle so nothing can lean on a stale instruction
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            req <= '0;
        end else if (issue) begin
            req <= ins;
        end else begin
            req <= idle;
        end
    end
endmodule : ceac_stream
`default_nettype wire
